//--- vipsw_top.sv
// Interrupt priority, vectoring and standby wake controller with Wishbone registers
// Summary of operation
// - Sixteen sources grouped onto ten vectors
// - Nested interrupts on three levels
// - Refuse requests at or below serviced level
// - Higher level wins among simultaneous vectors
// - Equal level: lowest vector address wins
// - Levels ordered highest, high, low
// - First two pins: highest or low
// - Shared vectors 13H and 1BH, high/low
// - Timer vectors 23H and 2BH, high/low
// - Serial, converter, port/PWM vectors, high/low
// - Fourth pin filtered, 1/32/128 cycles
// - Light standby stops CPU, reset releases
// - Deep standby stops all, oscillators off
// - Deep standby wakes on reset/pins/port
// - Crystal standby keeps base timer, crystal
// - Crystal standby also wakes on base timer
`timescale 1ns/1ps
module vipsw_top
    import vipsw_pkg::*;
#(
    parameter int TCYC_CLKS = TCYC_CLKS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire vipsw_src_s src_req,
    input wire logic reset_pin_low,
    input wire logic cpu_accept,
    input wire logic cpu_return,
    output logic irq,
    output logic vec_valid,
    output logic [15:0] vec_addr,
    output vipsw_lvl_e vec_level,
    output vipsw_run_s run_ctl,
    output vipsw_osc_s osc_en
);

    // Bus state
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic wr_en, rd_en;
    logic [31:0] bmask;

    // Interrupt state
    logic [NSRC-1:0] status_q, status_d;
    logic [NSRC-1:0] mask_q, mask_d;
    logic [NSRC-1:0] prev_q, prev_d;
    logic [NSRC-1:0] raw, rise;
    logic [NVEC-1:0] level_q, level_d;
    logic [1:0] filt_q, filt_d;
    logic [NVEC-1:0] pend;

    // Service stack: one bit per level, levels only nest upward
    logic [3:1] act_q, act_d;
    vipsw_lvl_e cur_lvl;
    logic do_ret;

    // Registered winner presented to the CPU
    logic win_valid_c;
    logic [VW-1:0] win_vec_c;
    vipsw_lvl_e win_lvl_c;
    logic win_valid_q;
    logic [VW-1:0] win_vec_q;
    vipsw_lvl_e win_lvl_q;

    // Standby state
    vipsw_st_e st_q, st_d;
    logic [2:0] osc_cfg_q, osc_cfg_d;
    logic xtal_keep_q, xtal_keep_d;
    logic [9:0] wake_q, wake_d;
    logic [NWAKE-1:0] wake_pins;
    logic wake_hold, wake_xhold;
    vipsw_run_s run_q, run_d;
    vipsw_osc_s osc_q, osc_d;

    logic ext_d_filt;

    vipsw_nfilt #(
        .TCYC_CLKS(TCYC_CLKS)
    ) u_filt (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(src_req.ext_irq_d_filtered),
        .sel(filt_q),
        .dout_q(ext_d_filt)
    );

    vipsw_arb u_arb (
        .pend(pend),
        .lvl_sel(level_q),
        .cur_lvl(cur_lvl),
        .win_valid(win_valid_c),
        .win_vec(win_vec_c),
        .win_lvl(win_lvl_c)
    );

    // ---------------- Wishbone slave ----------------

    always_comb begin
        wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
        rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        rdat_d = rdat_q;
        if (rd_en) begin
            rdat_d = 32'h0000_0000;
            case (wb_adr_i)
                REG_STATUS: begin
                    rdat_d[NSRC-1:0] = status_q;
                end
                REG_MASK: begin
                    rdat_d[NSRC-1:0] = mask_q;
                end
                REG_LEVEL: begin
                    rdat_d[NVEC-1:0] = level_q;
                end
                REG_FILTER: begin
                    rdat_d[1:0] = filt_q;
                end
                REG_SERVICE: begin
                    rdat_d[SV_ACT_LSB +: 3] = act_q;
                    rdat_d[SV_VEC_LSB +: VW] = win_vec_q;
                    rdat_d[SV_VALID_BIT] = win_valid_q;
                end
                REG_STANDBY: begin
                    rdat_d[SB_OSC_LSB +: 3] = osc_cfg_q;
                    rdat_d[SB_STATE_LSB +: 4] = st_q;
                end
                REG_WAKE: begin
                    rdat_d[9:0] = wake_q;
                end
                default: begin
                    rdat_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ---------------- Request capture ----------------

    always_comb begin
        raw = src_req;
        raw[SRC_EXT_D] = ext_d_filt;
        rise = raw & ~prev_q;
        prev_d = raw;
        status_d = status_q;
        mask_d = mask_q;
        level_d = level_q;
        filt_d = filt_q;
        if (wr_en && wb_adr_i == REG_STATUS) begin
            status_d = status_q & ~(wb_dat_i[NSRC-1:0] & bmask[NSRC-1:0]);
        end
        // A new edge wins over a clear in the same cycle
        status_d = status_d | rise;
        if (wr_en && wb_adr_i == REG_MASK) begin
            mask_d = (mask_q & ~bmask[NSRC-1:0]) | (wb_dat_i[NSRC-1:0] & bmask[NSRC-1:0]);
        end
        if (wr_en && wb_adr_i == REG_LEVEL) begin
            level_d = (level_q & ~bmask[NVEC-1:0]) | (wb_dat_i[NVEC-1:0] & bmask[NVEC-1:0]);
        end
        if (wr_en && wb_adr_i == REG_FILTER && wb_sel_i[0]) begin
            filt_d = wb_dat_i[1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
            mask_q <= MASK_RST;
            prev_q <= '0;
            level_q <= LEVEL_RST;
            filt_q <= FILTER_RST;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            prev_q <= prev_d;
            level_q <= level_d;
            filt_q <= filt_d;
        end
    end

    // Group the sources onto their vectors
    always_comb begin
        pend = '0;
        for (int s = 0; s < NSRC; s++) begin
            if (status_q[s] && mask_q[s]) begin
                pend[SRC_VEC[s]] = 1'b1;
            end
        end
    end

    assign irq = |(status_q & mask_q);

    // ---------------- Service level tracking ----------------

    always_comb begin
        if (act_q[3]) begin
            cur_lvl = LVL_TOP;
        end else if (act_q[2]) begin
            cur_lvl = LVL_HIGH;
        end else if (act_q[1]) begin
            cur_lvl = LVL_LOW;
        end else begin
            cur_lvl = LVL_NONE;
        end
        do_ret = cpu_return ||
                 (wr_en && wb_adr_i == REG_SERVICE && wb_sel_i[0] && wb_dat_i[SV_RET_BIT]);
        act_d = act_q;
        // Return drops the top level first, then a same-cycle accept is stacked
        if (do_ret) begin
            case (cur_lvl)
                LVL_TOP: act_d[3] = 1'b0;
                LVL_HIGH: act_d[2] = 1'b0;
                LVL_LOW: act_d[1] = 1'b0;
                default: act_d = act_q;
            endcase
        end
        if (cpu_accept && win_valid_q && win_lvl_q != LVL_NONE) begin
            act_d[win_lvl_q] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            act_q <= 3'h0;
            win_valid_q <= 1'b0;
            win_vec_q <= '0;
            win_lvl_q <= LVL_NONE;
        end else begin
            act_q <= act_d;
            // Winner is re-evaluated every cycle against the level held in act_q, so an accept blanks it for one cycle
            win_valid_q <= win_valid_c && !(cpu_accept && win_valid_q);
            win_vec_q <= win_vec_c;
            win_lvl_q <= win_lvl_c;
        end
    end

    assign vec_valid = win_valid_q;
    assign vec_addr = VEC_ADDR[win_vec_q];
    assign vec_level = win_lvl_q;

    // ---------------- Standby control ----------------

    always_comb begin
        for (int i = 0; i < NWAKE; i++) begin
            wake_pins[i] = 1'b0;
        end
        // Pins a, b, c, e, f may wake on a chosen level
        wake_pins[0] = wake_q[0] && (raw[0] == wake_q[WK_POL_LSB]);
        wake_pins[1] = wake_q[1] && (raw[1] == wake_q[WK_POL_LSB + 1]);
        wake_pins[2] = wake_q[2] && (raw[2] == wake_q[WK_POL_LSB + 2]);
        wake_pins[3] = wake_q[3] && (raw[4] == wake_q[WK_POL_LSB + 3]);
        wake_pins[4] = wake_q[4] && (raw[6] == wake_q[WK_POL_LSB + 4]);
        wake_hold = reset_pin_low || (|wake_pins) || rise[SRC_PORT0];
        wake_xhold = wake_hold || rise[SRC_BASE];
    end

    always_comb begin
        st_d = st_q;
        osc_cfg_d = osc_cfg_q;
        xtal_keep_d = xtal_keep_q;
        wake_d = wake_q;
        if (wr_en && wb_adr_i == REG_WAKE) begin
            wake_d = (wake_q & ~bmask[9:0]) | (wb_dat_i[9:0] & bmask[9:0]);
        end
        if (wr_en && wb_adr_i == REG_STANDBY && wb_sel_i[0]) begin
            osc_cfg_d = wb_dat_i[SB_OSC_LSB +: 3];
        end
        case (st_q)
            ST_RUN: begin
                if (wr_en && wb_adr_i == REG_STANDBY && wb_sel_i[0]) begin
                    case (wb_dat_i[SB_MODE_LSB +: 2])
                        MODE_HALT: st_d = ST_HALT;
                        MODE_HOLD: st_d = ST_HOLD;
                        MODE_XHOLD: begin
                            st_d = ST_XHOLD;
                            xtal_keep_d = osc_cfg_q[0];
                        end
                        default: st_d = ST_RUN;
                    endcase
                end
            end
            ST_HALT: begin
                // Left only through the system reset
                st_d = ST_HALT;
            end
            ST_HOLD: begin
                if (wake_hold) begin
                    st_d = ST_RUN;
                end
            end
            ST_XHOLD: begin
                if (wake_xhold) begin
                    st_d = ST_RUN;
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    always_comb begin
        run_d = '{cpu_run: 1'b1, periph_run: 1'b1, base_timer_run: 1'b1};
        osc_d = osc_cfg_q;
        case (st_d)
            ST_HALT: begin
                run_d.cpu_run = 1'b0;
            end
            ST_HOLD: begin
                run_d = '0;
                osc_d = '0;
            end
            ST_XHOLD: begin
                run_d = '{cpu_run: 1'b0, periph_run: 1'b0, base_timer_run: 1'b1};
                osc_d = '{ceramic_osc: 1'b0, rc_osc: 1'b0, xtal_osc: xtal_keep_d};
            end
            default: begin
                osc_d = osc_cfg_d;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_RUN;
            osc_cfg_q <= OSC_RST;
            xtal_keep_q <= 1'b0;
            wake_q <= WAKE_RST;
            run_q <= '1;
            osc_q <= OSC_RST;
        end else begin
            st_q <= st_d;
            osc_cfg_q <= osc_cfg_d;
            xtal_keep_q <= xtal_keep_d;
            wake_q <= wake_d;
            run_q <= run_d;
            osc_q <= osc_d;
        end
    end

    assign run_ctl = run_q;
    assign osc_en = osc_q;

endmodule

//--- vipsw_pkg.sv
// Shared constants and carrier types of the vectored interrupt and standby block
package vipsw_pkg;

    localparam int NSRC = 16;
    localparam int NVEC = 10;
    localparam int VW = 4;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_LEVEL = 8'h08;
    localparam logic [7:0] REG_FILTER = 8'h0C;
    localparam logic [7:0] REG_SERVICE = 8'h10;
    localparam logic [7:0] REG_STANDBY = 8'h14;
    localparam logic [7:0] REG_WAKE = 8'h18;

    // Reset values
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [9:0] LEVEL_RST = 10'h000;
    localparam logic [1:0] FILTER_RST = 2'h0;
    localparam logic [2:0] OSC_RST = 3'h7;
    localparam logic [9:0] WAKE_RST = 10'h000;

    // Field positions
    localparam int SB_MODE_LSB = 0;
    localparam int SB_OSC_LSB = 4;
    localparam int SB_STATE_LSB = 8;
    localparam int SV_RET_BIT = 0;
    localparam int SV_ACT_LSB = 4;
    localparam int SV_VEC_LSB = 8;
    localparam int SV_VALID_BIT = 12;
    localparam int WK_POL_LSB = 5;
    localparam int NWAKE = 5;

    // Noise filter time constants, in instruction cycles
    localparam int FILT_T1 = 1;
    localparam int FILT_T32 = 32;
    localparam int FILT_T128 = 128;
    localparam int TCYC_CLKS_DEF = 3;

    typedef enum logic [1:0] {
        LVL_NONE = 2'h0,
        LVL_LOW = 2'h1,
        LVL_HIGH = 2'h2,
        LVL_TOP = 2'h3
    } vipsw_lvl_e;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_HALT = 4'h2,
        ST_HOLD = 4'h4,
        ST_XHOLD = 4'h8
    } vipsw_st_e;

    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_HOLD = 2'h2;
    localparam logic [1:0] MODE_XHOLD = 2'h3;

    localparam logic [NVEC-1:0][15:0] VEC_ADDR = '{
        16'h004B, 16'h0043, 16'h003B, 16'h0033, 16'h002B,
        16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

    // Vector index of each source, source 0 in the low slot
    localparam logic [NSRC-1:0][VW-1:0] SRC_VEC = '{
        4'h9, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h5, 4'h4,
        4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h0};

    // Packed: the last field is source 0
    typedef struct packed {
        logic pulse_width_req;
        logic port_zero_req;
        logic adc_req;
        logic async_serial_req;
        logic sync_serial_req;
        logic timer_one_high_req;
        logic timer_one_low_req;
        logic timer_zero_high_req;
        logic base_timer_req;
        logic ext_irq_f;
        logic ext_irq_d_filtered;
        logic ext_irq_e;
        logic timer_zero_low_req;
        logic ext_irq_c;
        logic ext_irq_b;
        logic ext_irq_a;
    } vipsw_src_s;

    localparam int SRC_EXT_D = 5;
    localparam int SRC_BASE = 7;
    localparam int SRC_PORT0 = 14;

    typedef struct packed {
        logic ceramic_osc;
        logic rc_osc;
        logic xtal_osc;
    } vipsw_osc_s;

    typedef struct packed {
        logic cpu_run;
        logic periph_run;
        logic base_timer_run;
    } vipsw_run_s;

endpackage

//--- vipsw_nfilt.sv
// Noise rejection filter for one external interrupt input
`timescale 1ns/1ps
module vipsw_nfilt
    import vipsw_pkg::*;
#(
    parameter int TCYC_CLKS = TCYC_CLKS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic din,
    input wire logic [1:0] sel,
    output logic dout_q
);
    logic [7:0] div_q, div_d, cnt_q, cnt_d, limit;
    logic dout_d, tick;

    always_comb begin
        tick = (div_q == 8'(TCYC_CLKS - 1));
        div_d = tick ? 8'h00 : div_q + 8'h01;
        case (sel)
            2'h0: limit = 8'(FILT_T1);
            2'h1: limit = 8'(FILT_T32);
            default: limit = 8'(FILT_T128);
        endcase
        cnt_d = cnt_q;
        dout_d = dout_q;
        // Output follows only after a full time constant of stable input
        if (tick) begin
            if (din == dout_q) begin
                cnt_d = 8'h00;
            end else if (cnt_q + 8'h01 >= limit) begin
                cnt_d = 8'h00;
                dout_d = din;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
            cnt_q <= 8'h00;
            dout_q <= 1'b0;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
        end
    end
endmodule

//--- vipsw_arb.sv
// Priority arbiter over the pending vectors
`timescale 1ns/1ps
module vipsw_arb
    import vipsw_pkg::*;
(
    input wire logic [NVEC-1:0] pend,
    input wire logic [NVEC-1:0] lvl_sel,
    input wire vipsw_lvl_e cur_lvl,
    output logic win_valid,
    output logic [VW-1:0] win_vec,
    output vipsw_lvl_e win_lvl
);
    vipsw_lvl_e lv;

    always_comb begin
        win_valid = 1'b0;
        win_vec = '0;
        win_lvl = LVL_NONE;
        lv = LVL_NONE;
        // Scan downward so that on a tie the lower vector overrides
        for (int v = NVEC - 1; v >= 0; v--) begin
            if (!lvl_sel[v]) begin
                lv = LVL_LOW;
            end else if (v < 2) begin
                lv = LVL_TOP;
            end else begin
                lv = LVL_HIGH;
            end
            if (pend[v] && lv > cur_lvl && lv >= win_lvl) begin
                win_valid = 1'b1;
                win_vec = VW'(v);
                win_lvl = lv;
            end
        end
    end
endmodule

//--- vipsw_monitor.sv
// Port assertions for the interrupt priority and standby controller
`timescale 1ns/1ps
module vipsw_monitor
    import vipsw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic reset_pin_low,
    input wire logic cpu_accept,
    input wire logic cpu_return,
    input wire logic vec_valid,
    input wire logic [15:0] vec_addr,
    input wire vipsw_lvl_e vec_level,
    input wire vipsw_run_s run_ctl,
    input wire vipsw_osc_s osc_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    AST_VEC_MAP: assert property (vec_valid |-> vec_addr inside {16'h0003, 16'h000B,
        16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B})
        else $error("presented vector is not one of the ten");
    AST_LVL_SET: assert property (vec_valid |-> vec_level != LVL_NONE)
        else $error("presented vector has no level");
    AST_TOP_PINS: assert property (vec_valid && vec_level == LVL_TOP |->
        vec_addr inside {16'h0003, 16'h000B})
        else $error("highest level on a vector that cannot take it");
    AST_ACCEPT_MASK: assert property (cpu_accept && vec_valid && !cpu_return |=> !vec_valid)
        else $error("vector still shown right after acceptance");
    AST_HALT_OSC: assert property (run_ctl == 3'b011 && $past(run_ctl) == 3'b111 |->
        $stable(osc_en))
        else $error("oscillators changed on halt entry");
    AST_HALT_STAY: assert property (run_ctl == 3'b011 |=> run_ctl == 3'b011)
        else $error("halt left without reset");
    AST_HOLD_OFF: assert property (run_ctl == 3'b000 |-> osc_en == 3'b000)
        else $error("oscillator running in hold");
    AST_HOLD_WAKE: assert property (run_ctl == 3'b000 && reset_pin_low |=> run_ctl == 3'b111)
        else $error("hold not released by reset pin");
    AST_XHOLD_OSC: assert property (run_ctl == 3'b001 |->
        !osc_en.ceramic_osc && !osc_en.rc_osc)
        else $error("ceramic or rc oscillator running in crystal hold");

    COV_TOP: cover property (vec_valid && vec_level == LVL_TOP);
    COV_ACCEPT: cover property (cpu_accept && vec_valid);
    COV_HOLD: cover property (run_ctl == 3'b000);
    COV_XHOLD: cover property (run_ctl == 3'b001);
endmodule

bind vipsw_top vipsw_monitor u_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .reset_pin_low(reset_pin_low),
    .cpu_accept(cpu_accept),
    .cpu_return(cpu_return),
    .vec_valid(vec_valid),
    .vec_addr(vec_addr),
    .vec_level(vec_level),
    .run_ctl(run_ctl),
    .osc_en(osc_en)
);

//--- vipsw_periph_model.sv
// Peripheral request sources and the CPU vector-take sequencer
`timescale 1ns/1ps
module vipsw_periph_model
    import vipsw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire vipsw_src_s src_cmd,
    input wire logic take,
    input wire logic [3:0] dly,
    input wire logic vec_valid,
    output vipsw_src_s src_req,
    output logic cpu_accept
);
    logic [3:0] cnt_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            src_req <= '0;
            cpu_accept <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            src_req <= src_cmd;
            cpu_accept <= 1'b0;
            cnt_q <= 4'h0;
            // A slow CPU lets a shown vector wait dly cycles before taking it
            if (take && vec_valid && !cpu_accept) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= dly) begin
                    cpu_accept <= 1'b1;
                end
            end
        end
    end
endmodule

//--- vectored_irq_priority_standby_wake_tb.sv
// Self-checking bench for the interrupt priority and standby controller
`timescale 1ns/1ps
module vectored_irq_priority_standby_wake_tb
    import vipsw_pkg::*;
();
    logic ref_clk = 1'b0;
    logic rst = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd, wb_dat_o;
    logic wb_ack_o, irq, vec_valid, cpu_accept;
    logic cpu_return = 1'b0, reset_pin_low = 1'b0, take = 1'b0;
    logic [3:0] dly = 4'h3;
    logic [15:0] vec_addr;
    vipsw_lvl_e vec_level;
    vipsw_run_s run_ctl;
    vipsw_osc_s osc_en;
    vipsw_src_s src_req, src_cmd = '0;
    int errors = 0, tests_run = 0, tmo = 0;
    // Each row: source bit above, expected vector address below
    localparam logic [31:0] ROWS [16] = '{32'h00010003, 32'h0002000B, 32'h00040013,
        32'h00080013, 32'h00100013, 32'h0020001B, 32'h0040001B, 32'h0080001B, 32'h01000023,
        32'h0200002B, 32'h0400002B, 32'h08000033, 32'h1000003B, 32'h20000043, 32'h4000004B,
        32'h8000004B};

    vipsw_top #(.TCYC_CLKS(1)) u_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_req(src_req),
        .reset_pin_low(reset_pin_low), .cpu_accept(cpu_accept), .cpu_return(cpu_return),
        .irq(irq), .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_level(vec_level),
        .run_ctl(run_ctl), .osc_en(osc_en));
    vipsw_periph_model u_model (.ref_clk(ref_clk), .rst(rst), .src_cmd(src_cmd),
        .take(take), .dly(dly), .vec_valid(vec_valid), .src_req(src_req),
        .cpu_accept(cpu_accept));

    always #50 ref_clk = ~ref_clk;

    task automatic finish_test();
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang in any handshake wait ends up here instead of running forever
    always @(posedge ref_clk) begin
        tmo++;
        if (tmo == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [1:0] l, input logic [15:0] a);
        chk({14'h0, vec_level, vec_addr}, {14'h0, l, a});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = wb_dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge ref_clk);
    endtask

    task automatic wait_vv();
        while (vec_valid !== 1'b1) begin
            @(posedge ref_clk);
        end
    endtask

    task automatic accept();
        take <= 1'b1;
        while (cpu_accept !== 1'b1) begin
            @(posedge ref_clk);
        end
        take <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic ret();
        cpu_return <= 1'b1;
        @(posedge ref_clk);
        cpu_return <= 1'b0;
        @(posedge ref_clk);
    endtask

    initial begin
        int n;
        int lim;
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        chk({22'h0, vec_valid, irq, run_ctl, osc_en, vec_level}, 32'h000000FC);
        chk({16'h0, vec_addr}, 32'h00000003);
        src_cmd <= 16'h0001;
        tick(4);
        chk({30'h0, vec_valid, irq}, 32'h0);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h00000001);
        wb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, REG_MASK, 32'h0000FFFF);
        chk({31'h0, irq}, 32'h1);
        src_cmd <= '0;
        wb(1'b1, REG_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 16; i++) begin
            src_cmd <= ROWS[i][31:16];
            wait_vv();
            chk_vec(LVL_LOW, ROWS[i][15:0]);
            src_cmd <= '0;
            wb(1'b1, REG_STATUS, {16'h0, ROWS[i][31:16]});
            tick(2);
            chk({31'h0, vec_valid}, 32'h0);
        end
        wb(1'b1, REG_LEVEL, 32'h00000010);
        src_cmd <= 16'h0102;
        wait_vv();
        chk_vec(LVL_HIGH, 16'h0023);
        src_cmd <= '0;
        wb(1'b1, REG_STATUS, 32'h00000102);
        src_cmd <= 16'h0003;
        wait_vv();
        chk_vec(LVL_LOW, 16'h0003);
        wb(1'b1, REG_LEVEL, 32'h00000012);
        src_cmd <= 16'h0103;
        tick(6);
        chk_vec(LVL_TOP, 16'h000B);
        accept();
        tick(8);
        chk({31'h0, vec_valid}, 32'h0);
        wb(1'b1, REG_STATUS, 32'h00000002);
        ret();
        wait_vv();
        chk_vec(LVL_HIGH, 16'h0023);
        dly <= 4'h0;
        accept();
        tick(4);
        chk({31'h0, vec_valid}, 32'h0);
        wb(1'b0, REG_SERVICE, 32'h0);
        chk(rd, 32'h00000020);
        wb(1'b1, REG_STATUS, 32'h00000100);
        wb(1'b1, REG_SERVICE, 32'h00000001);
        wait_vv();
        chk_vec(LVL_LOW, 16'h0003);
        src_cmd <= '0;
        wb(1'b1, REG_STATUS, 32'h00000001);
        for (int k = 1; k < 3; k++) begin
            lim = (k == 1) ? FILT_T32 : FILT_T128;
            wb(1'b1, REG_FILTER, k);
            src_cmd <= 16'h0020;
            tick(10);
            src_cmd <= '0;
            tick(150);
            chk({31'h0, irq}, 32'h0);
            src_cmd <= 16'h0020;
            n = 0;
            while (irq !== 1'b1 && n < 400) begin
                tick(1);
                n++;
            end
            chk({31'h0, n >= lim - 4 && n <= lim + 8}, 32'h1);
            src_cmd <= '0;
            wb(1'b1, REG_STATUS, 32'h00000020);
            // Filter output must fall before the next pulse is judged
            tick(lim + 8);
        end
        wb(1'b1, REG_STANDBY, 32'h00000072);
        chk({26'h0, run_ctl, osc_en}, 32'h0);
        reset_pin_low <= 1'b1;
        tick(1);
        reset_pin_low <= 1'b0;
        tick(1);
        chk({29'h0, run_ctl}, 32'h7);
        wb(1'b1, REG_WAKE, 32'h00000021);
        wb(1'b1, REG_STANDBY, 32'h00000072);
        chk({29'h0, run_ctl}, 32'h0);
        src_cmd <= 16'h0001;
        tick(4);
        chk({29'h0, run_ctl}, 32'h7);
        src_cmd <= '0;
        wb(1'b1, REG_STATUS, 32'h00000001);
        wb(1'b1, REG_STANDBY, 32'h00000073);
        chk({26'h0, run_ctl, osc_en}, 32'h00000009);
        src_cmd <= 16'h0080;
        tick(4);
        chk({29'h0, run_ctl}, 32'h7);
        src_cmd <= '0;
        wb(1'b1, REG_STATUS, 32'h00000080);
        wb(1'b1, REG_STANDBY, 32'h00000071);
        chk({26'h0, run_ctl, osc_en}, 32'h0000001F);
        reset_pin_low <= 1'b1;
        src_cmd <= 16'h0080;
        tick(4);
        chk({29'h0, run_ctl}, 32'h3);
        reset_pin_low <= 1'b0;
        src_cmd <= '0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk({22'h0, vec_valid, irq, run_ctl, osc_en, vec_level}, 32'h000000FC);
        finish_test();
    end
endmodule
